/* File: regbits_checker.sv */
// Purpose: Assertions on the register bit cell bank.
// Assumes: Sees only the ports of the bank.
// Notes: Soft reset masks every access at bits_o (a read still loads rdata_o), so it gates each cause.
`timescale 1ns/1ps
module regbits_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_rst_i,
    input wire regbits_pkg::sw_access_t sw_i,
    input wire regbits_pkg::hw_events_t hw_i,
    input wire logic [regbits_pkg::BANK_W-1:0] rdata_o,
    input wire logic [regbits_pkg::BANK_W-1:0] bits_o
);
    wire rd = sw_i.rd && !soft_rst_i;
    wire wr = sw_i.wr && !soft_rst_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Tracks any read; cleared once the sticky bit is seen low without a read
    logic seen_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || soft_rst_i) begin
            seen_q <= 1'b0;
        end else if (sw_i.rd) begin
            seen_q <= 1'b1;
        end else if (!bits_o[9]) begin
            seen_q <= 1'b0;
        end
    end
    // ======================================
    // Access rules
    property p_rs; rd |=> bits_o[1]; endproperty
    a_rs: assert property (p_rs) else $error("read-set low");
    property p_w1c; wr && sw_i.wdata[4] && !hw_i.w1c_set |=> !bits_o[4];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c kept");
    property p_win; wr && sw_i.wdata[4] && hw_i.w1c_set |=> bits_o[4];
    endproperty
    a_win: assert property (p_win) else $error("event lost");
    property p_wc; wr && !hw_i.wc_set |=> !bits_o[5]; endproperty
    a_wc: assert property (p_wc) else $error("wc kept");
    property p_ll; rd && hw_i.ll_cond |=> bits_o[6]; endproperty
    a_ll: assert property (p_ll) else $error("ll not rearmed");
    property p_sc; wr && sw_i.wdata[8] ##1 !sw_i.wr |-> bits_o[8] ##1
        !bits_o[8]; endproperty
    a_sc: assert property (p_sc) else $error("sc stuck");
    property p_stk; bits_o[9] && !seen_q && !rd && !soft_rst_i |=>
        bits_o[9]; endproperty
    a_stk: assert property (p_stk) else $error("sticky fell");
    property p_stk_fall; seen_q && !hw_i.stk_cond && !soft_rst_i |=>
        !bits_o[9]; endproperty
    a_stk_fall: assert property (p_stk_fall) else $error("stuck");
    property p_keep; soft_rst_i |=> $stable(bits_o[10]); endproperty
    a_keep: assert property (p_keep) else $error("kept bit lost");
endmodule
bind register_bit_access_types regbits_checker u_chk (.clk_i, .sys_rst_i,
    .soft_rst_i, .sw_i, .hw_i, .rdata_o, .bits_o);

/* File: regbits_pkg.sv */
// Purpose: Shared constants and carriers for the register bit cell bank.
// Assumes: One register clock; software access arrives as strobes.
// Notes: Each cell kind occupies one bit position of a small bank.
//
// Functional notes
// - Read-only bit returns its value; software writes never change it.
// - Read-to-set bit becomes one whenever software reads it.
// - Write-only bit takes writes; its read data is not defined.
// - Write-one-to-set: a written one sets, a written zero does nothing.
// - Write-one-to-clear: a written one clears, a zero does nothing.
// - Write-anything-to-clear bit clears on any write, whatever the data.
// - Latch-low bit holds a low event until the register is read.
// - Latch-high bit holds a high event until the register is read.
// - Self-clearing bit drops to zero by itself; zero writes do nothing.
// - Sticky status stays high until read, then follows its condition.
// - Bits kept through soft reset hold their value during soft reset.
// - Reserved bits have no defined read value; software ignores them.
package regbits_pkg;

    localparam int unsigned BANK_W = 16;

    // ==========================================================
    // Bit positions within the bank
    localparam int unsigned B_RO   = 0;
    localparam int unsigned B_RS   = 1;
    localparam int unsigned B_WO   = 2;
    localparam int unsigned B_W1S  = 3;
    localparam int unsigned B_W1C  = 4;
    localparam int unsigned B_WC   = 5;
    localparam int unsigned B_LL   = 6;
    localparam int unsigned B_LH   = 7;
    localparam int unsigned B_SC   = 8;
    localparam int unsigned B_STK  = 9;
    localparam int unsigned B_KEEP = 10;
    localparam int unsigned B_RSV_LO = 11;
    localparam int unsigned B_RSV_HI = 15;

    // ==========================================================
    // Reset values
    localparam logic [BANK_W-1:0] RESET_VAL = 16'h0040;
    localparam logic [BANK_W-1:0] RSV_READ = 16'h0000;
    localparam logic [BANK_W-1:0] KEEP_MASK = 16'h0400;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [BANK_W-1:0] wdata;
    } sw_access_t;

    typedef struct packed {
        logic ro_val;
        logic ll_cond;
        logic lh_cond;
        logic stk_cond;
        logic w1c_set;
        logic wc_set;
    } hw_events_t;

endpackage

/* File: register_bit_access_types.sv */
// Purpose: Bank of register bits, one per documented access attribute.
// Assumes: rd and wr are one-cycle strobes; read data is registered.
// Notes: Reserved bits read as zero; software must not rely on it.
`timescale 1ns/1ps
module register_bit_access_types (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_rst_i,
    input wire regbits_pkg::sw_access_t sw_i,
    input wire regbits_pkg::hw_events_t hw_i,
    output logic [regbits_pkg::BANK_W-1:0] rdata_o,
    output logic [regbits_pkg::BANK_W-1:0] bits_o
);

    logic ro_q;
    logic rs_q;
    logic wo_q;
    logic w1s_q;
    logic w1c_q;
    logic wc_q;
    logic ll_q;
    logic lh_q;
    logic sc_q;
    logic stk_q;
    logic stk_d;
    logic stk_armed_q;
    logic stk_armed_d;
    logic keep_q;
    logic [regbits_pkg::BANK_W-1:0] bank;
    logic [regbits_pkg::BANK_W-1:0] rdata_d;
    logic rd;
    logic wr;
    logic [regbits_pkg::BANK_W-1:0] wd;

    assign rd = sw_i.rd;
    assign wr = sw_i.wr;
    assign wd = sw_i.wdata;

    // ==========================================================
    // Soft reset value of one cell: kept bits hold, others default
    function automatic logic soft_val(input int unsigned pos,
                                      input logic cur);
        logic keep;
        keep = regbits_pkg::KEEP_MASK[pos];
        return keep ? cur : regbits_pkg::RESET_VAL[pos];
    endfunction

    // ==========================================================
    // Read-only mirror; writes are not looked at
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ro_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_RO];
        end else if (soft_rst_i) begin
            ro_q <= soft_val(regbits_pkg::B_RO, ro_q);
        end else begin
            ro_q <= hw_i.ro_val;
        end
    end

    // ==========================================================
    // Read-to-set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rs_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_RS];
        end else if (soft_rst_i) begin
            rs_q <= soft_val(regbits_pkg::B_RS, rs_q);
        end else if (rd) begin
            rs_q <= 1'b1;
        end
    end

    // ==========================================================
    // Write-only storage
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wo_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_WO];
        end else if (soft_rst_i) begin
            wo_q <= soft_val(regbits_pkg::B_WO, wo_q);
        end else if (wr) begin
            wo_q <= wd[regbits_pkg::B_WO];
        end
    end

    // ==========================================================
    // Write-one-to-set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w1s_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_W1S];
        end else if (soft_rst_i) begin
            w1s_q <= soft_val(regbits_pkg::B_W1S, w1s_q);
        end else if (wr && wd[regbits_pkg::B_W1S]) begin
            w1s_q <= 1'b1;
        end
    end

    // ==========================================================
    // Write-one-to-clear; a hardware event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w1c_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_W1C];
        end else if (soft_rst_i) begin
            w1c_q <= soft_val(regbits_pkg::B_W1C, w1c_q);
        end else if (hw_i.w1c_set) begin
            w1c_q <= 1'b1;
        end else if (wr && wd[regbits_pkg::B_W1C]) begin
            w1c_q <= 1'b0;
        end
    end

    // ==========================================================
    // Write-anything-to-clear; a hardware event still wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wc_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_WC];
        end else if (soft_rst_i) begin
            wc_q <= soft_val(regbits_pkg::B_WC, wc_q);
        end else if (hw_i.wc_set) begin
            wc_q <= 1'b1;
        end else if (wr) begin
            wc_q <= 1'b0;
        end
    end

    // ==========================================================
    // Latch low: read re-arms to one, a low condition still wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ll_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_LL];
        end else if (soft_rst_i) begin
            ll_q <= soft_val(regbits_pkg::B_LL, ll_q);
        end else if (!hw_i.ll_cond) begin
            ll_q <= 1'b0;
        end else if (rd) begin
            ll_q <= 1'b1;
        end
    end

    // ==========================================================
    // Latch high: read clears, a high condition still wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lh_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_LH];
        end else if (soft_rst_i) begin
            lh_q <= soft_val(regbits_pkg::B_LH, lh_q);
        end else if (hw_i.lh_cond) begin
            lh_q <= 1'b1;
        end else if (rd) begin
            lh_q <= 1'b0;
        end
    end

    // ==========================================================
    // Self-clearing: one-cycle pulse after a written one
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sc_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_SC];
        end else if (soft_rst_i) begin
            sc_q <= soft_val(regbits_pkg::B_SC, sc_q);
        end else begin
            sc_q <= wr && wd[regbits_pkg::B_SC];
        end
    end

    // ==========================================================
    // Sticky status: held high until read; after a read it follows
    // the condition. The armed flag remembers that a read happened
    // after which the bit stays high, so a later drop is not missed.
    always_comb begin
        stk_d = hw_i.stk_cond | (stk_q & ~(rd | stk_armed_q));
        stk_armed_d = (rd | stk_armed_q) & stk_d;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stk_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_STK];
        end else if (soft_rst_i) begin
            stk_q <= soft_val(regbits_pkg::B_STK, stk_q);
        end else begin
            stk_q <= stk_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stk_armed_q <= 1'b0;
        end else if (soft_rst_i) begin
            stk_armed_q <= 1'b0;
        end else begin
            stk_armed_q <= stk_armed_d;
        end
    end

    // ==========================================================
    // Plain storage that survives soft reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            keep_q <= regbits_pkg::RESET_VAL[regbits_pkg::B_KEEP];
        end else if (soft_rst_i) begin
            keep_q <= soft_val(regbits_pkg::B_KEEP, keep_q);
        end else if (wr) begin
            keep_q <= wd[regbits_pkg::B_KEEP];
        end
    end

    // ==========================================================
    // Bank view; reserved storage does not exist
    always_comb begin
        bank = '0;
        bank[regbits_pkg::B_RO] = ro_q;
        bank[regbits_pkg::B_RS] = rs_q;
        bank[regbits_pkg::B_WO] = wo_q;
        bank[regbits_pkg::B_W1S] = w1s_q;
        bank[regbits_pkg::B_W1C] = w1c_q;
        bank[regbits_pkg::B_WC] = wc_q;
        bank[regbits_pkg::B_LL] = ll_q;
        bank[regbits_pkg::B_LH] = lh_q;
        bank[regbits_pkg::B_SC] = sc_q;
        bank[regbits_pkg::B_STK] = stk_q;
        bank[regbits_pkg::B_KEEP] = keep_q;
        bank[regbits_pkg::B_RSV_HI:regbits_pkg::B_RSV_LO] =
            regbits_pkg::RSV_READ[regbits_pkg::B_RSV_HI:
                                  regbits_pkg::B_RSV_LO];
    end

    // ==========================================================
    // Read data: value before any read side effect
    always_comb begin
        rdata_d = bank;
        rdata_d[regbits_pkg::B_WO] = 1'b0;
        rdata_d[regbits_pkg::B_RSV_HI:regbits_pkg::B_RSV_LO] =
            regbits_pkg::RSV_READ[regbits_pkg::B_RSV_HI:
                                  regbits_pkg::B_RSV_LO];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (rd) begin
            rdata_o <= rdata_d;
        end
    end

    assign bits_o = bank;

endmodule

/* File: test_register_bit_access_types.sv */
// Purpose: Self-checking bench for the register bit cell bank.
// Assumes: Effects land one clock after each strobe.
// Notes: Write-only and reserved read data are never compared.
`timescale 1ns/1ps
module test_register_bit_access_types;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h want %h", $time, a, e); end end
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic soft_rst_i = 1'b0;
    regbits_pkg::sw_access_t sw = '0;
    regbits_pkg::hw_events_t hw = 6'h10;
    logic [regbits_pkg::BANK_W-1:0] rdata;
    logic [regbits_pkg::BANK_W-1:0] bits;
    int errors = 0;
    int checks_done = 0;
    always #4 clk_i = ~clk_i;
    register_bit_access_types dut (.clk_i, .sys_rst_i, .soft_rst_i,
        .sw_i(sw), .hw_i(hw), .rdata_o(rdata), .bits_o(bits));
    // ======================================
    // Scenarios
    task automatic acc(input logic r, input logic w, input logic [15:0] d);
        @(negedge clk_i);
        sw = '{rd: r, wr: w, wdata: d};
        @(negedge clk_i);
        sw = '0;
    endtask
    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_wr();
        hw.ro_val = 1'b1;
        acc(1'b0, 1'b1, 16'h07FE);
        `CHK(bits & 16'hFFFB, 16'h0549)
        @(negedge clk_i);
        `CHK(bits[8], 1'b0)
        acc(1'b0, 1'b1, 16'h0000);
        `CHK(bits[3], 1'b1)
    endtask
    task automatic t_clr();
        hw.w1c_set = 1'b1;
        hw.wc_set = 1'b1;
        acc(1'b0, 1'b1, 16'h0010);
        `CHK(bits[5:4], 2'h3)
        hw.w1c_set = 1'b0;
        hw.wc_set = 1'b0;
        acc(1'b0, 1'b1, 16'h0000);
        `CHK(bits[5:4], 2'h1)
        acc(1'b0, 1'b1, 16'h0010);
        `CHK(bits[4], 1'b0)
    endtask
    task automatic t_rd();
        hw = 6'h24;
        @(negedge clk_i);
        hw = 6'h18;
        @(negedge clk_i);
        `CHK(bits[9:6], 4'hA)
        hw = 6'h10;
        acc(1'b1, 1'b0, 16'h0000);
        `CHK(rdata[9:6], 4'hA)
        `CHK(bits[9:6], 4'h1)
        `CHK(bits[1], 1'b1)
        hw.stk_cond = 1'b1;
        acc(1'b1, 1'b0, 16'h0000);
        `CHK(bits[9], 1'b1)
        hw.stk_cond = 1'b0;
        @(negedge clk_i);
        `CHK(bits[9], 1'b0)
    endtask
    task automatic t_soft();
        acc(1'b0, 1'b1, 16'h0400);
        soft_rst_i = 1'b1;
        @(negedge clk_i);
        `CHK(bits, 16'h0440)
        soft_rst_i = 1'b0;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        `CHK(bits, 16'h0040)
        t_wr();
        t_clr();
        t_rd();
        t_soft();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        final_report();
    end
endmodule
